// file: verilog/rcsm_consts.vh
`ifndef RCSM_CONSTS_VH
`define RCSM_CONSTS_VH
// register offsets (byte addresses)
`define RCSM_OFF_STROBE      8'h00
`define RCSM_OFF_CFG0        8'h04
`define RCSM_OFF_CFG1        8'h08
`define RCSM_OFF_CFG2        8'h0C
`define RCSM_OFF_STATE       8'h10
`define RCSM_OFF_RXTIME      8'h14
// strobe command codes
`define RCSM_CMD_RX          8'h01
`define RCSM_CMD_TX          8'h02
`define RCSM_CMD_SYNTH_READY_TX_STATE      8'h03
`define RCSM_CMD_IDLE        8'h04
`define RCSM_CMD_CAL         8'h05
// config field positions
`define RCSM_CFG0_AUTOCAL_LO 0
`define RCSM_CFG1_TXOFF_LO   0
`define RCSM_CFG1_RXOFF_LO   2
`define RCSM_CFG1_CCA_LO     4
`define RCSM_CFG2_QUAL_BIT   0
`define RCSM_CFG2_CSTERM_BIT 1
// reset values
`define RCSM_CFG0_RST        8'h00
`define RCSM_CFG1_RST        8'h30
`define RCSM_CFG2_RST        8'h00
`define RCSM_RXTIME_RST      16'h0000
// state numbers
`define RCSM_ST_IDLE         5'h01
`define RCSM_ST_CAL          5'h08
`define RCSM_ST_SETTLE       5'h09
`define RCSM_ST_RX           5'h0D
`define RCSM_ST_SYNTH_READY_TX_STATE       5'h12
`define RCSM_ST_TX           5'h13
`define RCSM_ST_TURN         5'h15
`define RCSM_ST_END          5'h16
// timing in system clock cycles
`define RCSM_T_MANCAL        19098
`define RCSM_T_IDLE_RX       16'h07A1
`define RCSM_T_IDLE_TX       16'h07A2
`define RCSM_T_WITH_CAL      20768
`define RCSM_T_TURN          16'h030E
`define RCSM_T_RX_IDLE       16'h0002
`define RCSM_T_RX_IDLE_CAL   18817
`define RCSM_T_TX_IDLE_CAL   18815
`endif

// file: verilog/rcsm_delay.v
`default_nettype none
// loadable down counter, done pulses when it reaches zero
module rcsm_delay
#(
    parameter W = 16
)
(
    // clock and reset
    input  wire         sys_clk,
    input  wire         nrst,
    // control
    input  wire         load,
    input  wire [W-1:0] count,
    input  wire         abort,
    // status
    output reg          done,
    output reg          busy
);
    reg [W-1:0] cnt_reg; // remaining cycles

    // counter; load wins over abort so a restart is never lost
    always @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            cnt_reg <= {W{1'b0}};
            busy    <= 1'b0;
            done    <= 1'b0;
        end
        else if (load)
        begin
            cnt_reg <= count;
            busy    <= 1'b1;
            done    <= 1'b0;
        end
        else if (abort)
        begin
            busy <= 1'b0;
            done <= 1'b0;
        end
        else if (busy)
        begin
            done    <= (cnt_reg == {{(W-1){1'b0}}, 1'b1});
            busy    <= (cnt_reg != {{(W-1){1'b0}}, 1'b1});
            cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
        end
        else
        begin
            done <= 1'b0;
        end
    end
endmodule // rcsm_delay
`default_nettype wire

// file: verilog/rcsm_ctrl.v
// Operation
// - state changes only on strobes or events
// - state number readable in status register
// - receive/transmit strobes start those modes
// - autocal chooses one of three points
// - calibrate strobe in idle, 19098 cycles
// - idle strobe return never calibrates
// - receive holds until packet or timeout
// - after receive go per field
// - stay-in-receive invalidates RSSI briefly
// - transmit holds until sent, then field
// - receive strobe ends transmission
// - tx strobes in receive need clear channel
// - idle strobe forces idle always
// - termination timer starts at receive entry
// - continue condition sync, or sync/preamble
// - idle to receive 1953 or 20768
// - idle to transmit 1954 or 20768
// - rx/tx switch 782, plus quarter symbol
// - receive to idle 2 or 18817
// - transmit to idle quarter symbol or +18815
// - carrier sense termination on first sample
// - no carrier or no sync returns idle
// - channel clear mode four requirements
`include "rcsm_consts.vh"
`default_nettype none
module rcsm_ctrl
#(
    parameter QSYM_CYCLES = 20,           // quarter symbol in sys_clk cycles
    parameter RSSI_CYCLES = 100,          // rssi response time in cycles
    parameter T_MANCAL    = `RCSM_T_MANCAL,
    parameter T_WITH_CAL  = `RCSM_T_WITH_CAL,
    parameter T_RXI_CAL   = `RCSM_T_RX_IDLE_CAL,
    parameter T_TXI_CAL   = `RCSM_T_TX_IDLE_CAL,
    parameter RXT_SCALE   = 64            // cycles per timeout unit
)
(
    // clock and reset
    input  wire        sys_clk,
    input  wire        nrst,
    // register port
    input  wire [7:0]  addr,
    input  wire [31:0] wdata,
    input  wire        wr,
    input  wire        rd,
    output reg  [31:0] rdata,
    // events from modem and packet engine
    input  wire        pkt_rx_done,
    input  wire        pkt_tx_done,
    input  wire        tx_underflow,
    input  wire        sync_found,
    input  wire        pq_reached,
    input  wire        cs_valid,
    input  wire        carrier,
    input  wire        rssi_below,
    input  wire        rx_busy,
    // radio status outputs
    output reg  [4:0]  radio_state_number,
    output reg         synth_cal,
    output reg         rx_on,
    output reg         tx_on,
    output reg         rssi_valid
);
    // configuration
    reg [7:0]  cfg0_reg;       // auto_calibration_select
    reg [7:0]  cfg1_reg;       // after states, channel_clear_mode
    reg [7:0]  cfg2_reg;       // timeout qualifiers
    reg [15:0] rxtime_reg;     // receive timeout units, zero disables
    // state
    reg [4:0]  st_reg;         // state number
    reg [4:0]  tgt_reg;        // destination after a timed phase
    reg [1:0]  ret_cnt_reg;    // counts automatic returns to idle while autocal is 11
    reg        cs_seen_reg;    // first carrier sample already judged
    reg [31:0] rxt_reg;        // receive termination timer
    reg [15:0] rssi_cnt_reg;   // rssi settle counter
    // counter interface
    reg        dl_load;
    reg [15:0] dl_count;
    wire       dl_done;
    wire       dl_busy;
    wire [1:0] autocal   = cfg0_reg[`RCSM_CFG0_AUTOCAL_LO +: 2];
    wire [1:0] txoff     = cfg1_reg[`RCSM_CFG1_TXOFF_LO +: 2];
    wire [1:0] rxoff     = cfg1_reg[`RCSM_CFG1_RXOFF_LO +: 2];
    wire [1:0] channel_clear_mode  = cfg1_reg[`RCSM_CFG1_CCA_LO +: 2];
    wire       time_qual = cfg2_reg[`RCSM_CFG2_QUAL_BIT];
    wire       cs_term   = cfg2_reg[`RCSM_CFG2_CSTERM_BIT];
    // one strobe per write cycle
    wire       strobe  = wr && (addr == `RCSM_OFF_STROBE);
    wire       s_rx    = strobe && (wdata[7:0] == `RCSM_CMD_RX);
    wire       s_tx    = strobe && (wdata[7:0] == `RCSM_CMD_TX);
    wire       s_fs    = strobe && (wdata[7:0] == `RCSM_CMD_SYNTH_READY_TX_STATE);
    wire       s_idle  = strobe && (wdata[7:0] == `RCSM_CMD_IDLE);
    wire       s_cal   = strobe && (wdata[7:0] == `RCSM_CMD_CAL);
    // clear channel per mode
    reg cca_ok;
    always @*
    begin
        case (channel_clear_mode)
            2'b00:   cca_ok = 1'b1;
            2'b01:   cca_ok = rssi_below;
            2'b10:   cca_ok = !rx_busy;
            default: cca_ok = rssi_below && !rx_busy;
        endcase
    end
    // timeout expired and stay condition fails
    wire rx_keep    = sync_found || (time_qual && pq_reached);
    wire rxt_expire = (rxtime_reg != 16'h0000) && (rxt_reg == 32'h0000_0001);
    wire cs_fail    = cs_term && !cs_seen_reg && cs_valid && !carrier;
    // does the next automatic return to idle calibrate
    wire auto_cal_ret = (autocal == 2'b10) ||
                        ((autocal == 2'b11) && (ret_cnt_reg == 2'b11));
    rcsm_delay #(
        .W (16)
    ) u_delay (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .load    (dl_load),
        .count   (dl_count),
        .abort   (s_idle),
        .done    (dl_done),
        .busy    (dl_busy)
    );
    // next-state decision
    reg [4:0] st_next;
    reg [4:0] tgt_next;
    reg       ret_auto;    // automatic return to idle happened
    reg       rssi_restart;
    always @*
    begin
        st_next      = st_reg;
        tgt_next     = tgt_reg;
        dl_load      = 1'b0;
        dl_count     = 16'h0000;
        ret_auto     = 1'b0;
        rssi_restart = 1'b0;
        if (s_idle)
        begin
            st_next = `RCSM_ST_IDLE;
        end
        else
        begin
            case (st_reg)
                `RCSM_ST_IDLE:
                begin
                    if (s_cal)
                    begin
                        st_next  = `RCSM_ST_CAL;
                        tgt_next = `RCSM_ST_IDLE;
                        dl_load  = 1'b1;
                        dl_count = T_MANCAL[15:0];
                    end
                    else if (s_rx || s_tx || s_fs)
                    begin
                        st_next  = (autocal == 2'b01) ? `RCSM_ST_CAL : `RCSM_ST_SETTLE;
                        tgt_next = s_rx ? `RCSM_ST_RX : (s_tx ? `RCSM_ST_TX : `RCSM_ST_SYNTH_READY_TX_STATE);
                        dl_load  = 1'b1;
                        if (autocal == 2'b01)
                            dl_count = T_WITH_CAL[15:0];
                        else if (s_rx)
                            dl_count = `RCSM_T_IDLE_RX;
                        else
                            dl_count = `RCSM_T_IDLE_TX;
                    end
                end
                `RCSM_ST_SYNTH_READY_TX_STATE:
                begin
                    if (s_tx || s_rx)
                    begin
                        st_next  = `RCSM_ST_TURN;
                        tgt_next = s_tx ? `RCSM_ST_TX : `RCSM_ST_RX;
                        dl_load  = 1'b1;
                        dl_count = `RCSM_T_TURN;
                    end
                end
                `RCSM_ST_RX:
                begin
                    if ((s_tx || s_fs) && cca_ok)
                    begin
                        st_next  = `RCSM_ST_TURN;
                        tgt_next = s_tx ? `RCSM_ST_TX : `RCSM_ST_SYNTH_READY_TX_STATE;
                        dl_load  = 1'b1;
                        dl_count = `RCSM_T_TURN;
                    end
                    else if (cs_fail || (rxt_expire && !rx_keep))
                    begin
                        st_next  = auto_cal_ret ? `RCSM_ST_CAL : `RCSM_ST_END;
                        tgt_next = `RCSM_ST_IDLE;
                        ret_auto = 1'b1;
                        dl_load  = 1'b1;
                        dl_count = auto_cal_ret ? T_RXI_CAL[15:0] : `RCSM_T_RX_IDLE;
                    end
                    else if (pkt_rx_done)
                    begin
                        case (rxoff)
                            2'b00:
                            begin
                                st_next  = auto_cal_ret ? `RCSM_ST_CAL : `RCSM_ST_END;
                                tgt_next = `RCSM_ST_IDLE;
                                ret_auto = 1'b1;
                                dl_load  = 1'b1;
                                dl_count = auto_cal_ret ? T_RXI_CAL[15:0] : `RCSM_T_RX_IDLE;
                            end
                            2'b01, 2'b10:
                            begin
                                st_next  = `RCSM_ST_TURN;
                                tgt_next = (rxoff == 2'b01) ? `RCSM_ST_SYNTH_READY_TX_STATE : `RCSM_ST_TX;
                                dl_load  = 1'b1;
                                dl_count = `RCSM_T_TURN;
                            end
                            default: rssi_restart = 1'b1;
                        endcase
                    end
                end
                `RCSM_ST_TX:
                begin
                    if (s_rx)
                    begin
                        st_next  = `RCSM_ST_TURN;
                        tgt_next = `RCSM_ST_RX;
                        dl_load  = 1'b1;
                        dl_count = `RCSM_T_TURN + QSYM_CYCLES[15:0];
                    end
                    else if (pkt_tx_done || tx_underflow)
                    begin
                        dl_load = 1'b1;
                        case (tx_underflow ? 2'b00 : txoff)
                            2'b00:
                            begin
                                st_next  = auto_cal_ret ? `RCSM_ST_CAL : `RCSM_ST_END;
                                tgt_next = `RCSM_ST_IDLE;
                                ret_auto = 1'b1;
                                dl_count = auto_cal_ret ? T_TXI_CAL[15:0] + QSYM_CYCLES[15:0]
                                                        : QSYM_CYCLES[15:0];
                            end
                            2'b01:
                            begin
                                st_next  = `RCSM_ST_END;
                                tgt_next = `RCSM_ST_SYNTH_READY_TX_STATE;
                                dl_count = QSYM_CYCLES[15:0];
                            end
                            2'b10:
                            begin
                                st_next  = `RCSM_ST_END;
                                tgt_next = `RCSM_ST_TX;
                                dl_count = QSYM_CYCLES[15:0];
                            end
                            default:
                            begin
                                st_next  = `RCSM_ST_TURN;
                                tgt_next = `RCSM_ST_RX;
                                dl_count = `RCSM_T_TURN + QSYM_CYCLES[15:0];
                            end
                        endcase
                    end
                end
                `RCSM_ST_CAL, `RCSM_ST_SETTLE, `RCSM_ST_TURN, `RCSM_ST_END:
                begin
                    if (dl_done)
                        st_next = tgt_reg;
                end
                default: st_next = `RCSM_ST_IDLE;
            endcase
        end
    end

    // single state register and the cycle counters
    always @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            st_reg       <= `RCSM_ST_IDLE;
            tgt_reg      <= `RCSM_ST_IDLE;
            ret_cnt_reg  <= 2'b00;
            cs_seen_reg  <= 1'b0;
            rxt_reg      <= 32'h0000_0000;
            rssi_cnt_reg <= 16'h0000;
        end
        else
        begin
            st_reg  <= st_next;
            tgt_reg <= tgt_next;
            if (ret_auto && autocal == 2'b11)
                ret_cnt_reg <= ret_cnt_reg + 2'b01;
            // timer restarts on every entry to receive
            if (st_next == `RCSM_ST_RX && st_reg != `RCSM_ST_RX)
            begin
                rxt_reg     <= rxtime_reg * RXT_SCALE;
                cs_seen_reg <= 1'b0;
            end
            else if (rxt_reg != 32'h0000_0000)
                rxt_reg <= rxt_reg - 32'h0000_0001;
            if (st_reg == `RCSM_ST_RX && cs_valid)
                cs_seen_reg <= 1'b1;
            // rssi is stale until it settles again
            if (rssi_restart || (st_next == `RCSM_ST_RX && st_reg != `RCSM_ST_RX))
                rssi_cnt_reg <= RSSI_CYCLES[15:0];
            else if (rssi_cnt_reg != 16'h0000)
                rssi_cnt_reg <= rssi_cnt_reg - 16'h0001;
        end
    end

    // registered radio status outputs
    always @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            radio_state_number <= `RCSM_ST_IDLE;
            synth_cal          <= 1'b0;
            rx_on              <= 1'b0;
            tx_on              <= 1'b0;
            rssi_valid         <= 1'b0;
        end
        else
        begin
            radio_state_number <= st_next;
            synth_cal          <= (st_next == `RCSM_ST_CAL);
            rx_on              <= (st_next == `RCSM_ST_RX);
            tx_on              <= (st_next == `RCSM_ST_TX);
            rssi_valid         <= (st_reg == `RCSM_ST_RX) && (rssi_cnt_reg == 16'h0000)
                                  && !rssi_restart;
        end
    end

    // register writes; software owns the test tuning setup
    always @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            cfg0_reg   <= `RCSM_CFG0_RST;
            cfg1_reg   <= `RCSM_CFG1_RST;
            cfg2_reg   <= `RCSM_CFG2_RST;
            rxtime_reg <= `RCSM_RXTIME_RST;
        end
        else if (wr)
        begin
            case (addr)
                `RCSM_OFF_CFG0:   cfg0_reg   <= wdata[7:0];
                `RCSM_OFF_CFG1:   cfg1_reg   <= wdata[7:0];
                `RCSM_OFF_CFG2:   cfg2_reg   <= wdata[7:0];
                `RCSM_OFF_RXTIME: rxtime_reg <= wdata[15:0];
                default:          cfg0_reg   <= cfg0_reg;
            endcase
        end
    end

    // read data one cycle after the strobe, zero otherwise
    always @(posedge sys_clk)
    begin
        if (!nrst)
            rdata <= 32'h0000_0000;
        else if (rd)
        begin
            case (addr)
                `RCSM_OFF_CFG0:   rdata <= {24'h00_0000, cfg0_reg};
                `RCSM_OFF_CFG1:   rdata <= {24'h00_0000, cfg1_reg};
                `RCSM_OFF_CFG2:   rdata <= {24'h00_0000, cfg2_reg};
                `RCSM_OFF_RXTIME: rdata <= {16'h0000, rxtime_reg};
                `RCSM_OFF_STATE:  rdata <= {27'h000_0000, st_reg};
                default:          rdata <= 32'h0000_0000;
            endcase
        end
        else
            rdata <= 32'h0000_0000;
    end
endmodule // rcsm_ctrl
`default_nettype wire

// file: bench/rcsm_ctrl_monitor.sv
`include "rcsm_consts.vh"
`default_nettype none
// port-level checker for the radio control state machine
module rcsm_ctrl_monitor
(
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        nrst,
    // register port
    input wire logic [7:0]  addr,
    input wire logic [31:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [31:0] rdata,
    // events and levels
    input wire logic        pkt_rx_done,
    input wire logic        pkt_tx_done,
    input wire logic        tx_underflow,
    input wire logic        sync_found,
    input wire logic        pq_reached,
    input wire logic        cs_valid,
    input wire logic        carrier,
    input wire logic        rssi_below,
    input wire logic        rx_busy,
    // radio status
    input wire logic [4:0]  radio_state_number,
    input wire logic        synth_cal,
    input wire logic        rx_on,
    input wire logic        tx_on,
    input wire logic        rssi_valid
);
    timeunit 1ns;
    timeprecision 1ns;

    default clocking mon_cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    // a strobe write carrying a given command code
    sequence s_cmd(code);
        wr && addr == `RCSM_OFF_STROBE && wdata[7:0] == code;
    endsequence

    // receive requested while idle: only the settle or cal states may follow
    sequence s_rx_from_idle;
        s_cmd(`RCSM_CMD_RX) ##0 radio_state_number == `RCSM_ST_IDLE;
    endsequence

    AST_RESET_IDLE: assert property ($rose(nrst) |-> radio_state_number == `RCSM_ST_IDLE)
        else $error("state not idle after reset");
    AST_IDLE_WINS: assert property (s_cmd(`RCSM_CMD_IDLE) |=> radio_state_number == `RCSM_ST_IDLE)
        else $error("idle strobe did not force idle");
    AST_IDLE_HOLDS: assert property (radio_state_number == `RCSM_ST_IDLE && !wr |=> $stable(radio_state_number))
        else $error("idle left without a strobe");
    AST_RX_START: assert property (s_rx_from_idle |=> (radio_state_number inside {`RCSM_ST_SETTLE, `RCSM_ST_CAL})[*8])
        else $error("receive start sequence wrong");
    AST_TX_ABORT: assert property (radio_state_number == `RCSM_ST_TX ##0 s_cmd(`RCSM_CMD_RX) |=> !tx_on)
        else $error("transmit kept after receive strobe");
    AST_STATE_READ: assert property (rd && addr == `RCSM_OFF_STATE |=> rdata == {27'h0, $past(radio_state_number)})
        else $error("state register read mismatch");
    AST_RDATA_IDLE: assert property (!rd |=> rdata == 32'h0)
        else $error("read data not zero outside read");
    AST_RX_FLAG: assert property (rx_on == (radio_state_number == `RCSM_ST_RX))
        else $error("rx_on disagrees with state");
    AST_TX_FLAG: assert property (tx_on == (radio_state_number == `RCSM_ST_TX))
        else $error("tx_on disagrees with state");
    AST_CAL_FLAG: assert property (synth_cal == (radio_state_number == `RCSM_ST_CAL))
        else $error("synth_cal disagrees with state");
endmodule // rcsm_ctrl_monitor
`default_nettype wire

// file: bench/testbench.sv
`include "rcsm_consts.vh"
`default_nettype none
// directed bench for the radio control state machine
module testbench;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int T_SHORT = 50;   // shortened calibration counts
    localparam int QSYM    = 20;   // quarter symbol in cycles

    logic        sys_clk, nrst, wr, rd;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata;
    logic        pkt_rx_done, pkt_tx_done, tx_underflow, sync_found, pq_reached;
    logic        cs_valid, carrier, rssi_below, rx_busy;
    logic [4:0]  radio_state_number;
    logic        synth_cal, rx_on, tx_on, rssi_valid;
    int          err_total, n_compared;

    rcsm_ctrl #(.QSYM_CYCLES(QSYM), .T_MANCAL(T_SHORT), .T_WITH_CAL(T_SHORT),
        .T_RXI_CAL(T_SHORT), .T_TXI_CAL(T_SHORT)) rcsm_ctrl_i (
        .sys_clk(sys_clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .pkt_rx_done(pkt_rx_done), .pkt_tx_done(pkt_tx_done),
        .tx_underflow(tx_underflow), .sync_found(sync_found), .pq_reached(pq_reached),
        .cs_valid(cs_valid), .carrier(carrier), .rssi_below(rssi_below),
        .rx_busy(rx_busy), .radio_state_number(radio_state_number),
        .synth_cal(synth_cal), .rx_on(rx_on), .tx_on(tx_on), .rssi_valid(rssi_valid));

    // 20 MHz system clock
    always #25 sys_clk = ~sys_clk;

    // one compare for every kind of result, widened to 32 bits
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    // one-cycle write; returns just after the edge that took it
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        wr <= 1'b1; addr <= a; wdata <= d;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask

    task automatic strobe(input logic [7:0] code);
        wr_reg(`RCSM_OFF_STROBE, {24'h0, code});
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        rd <= 1'b1; addr <= a;
        @(posedge sys_clk);
        rd <= 1'b0;
        @(negedge sys_clk);
        chk(rdata, exp);
    endtask

    // bounded wait for a state; n_exp > 0 also checks the edge count
    task automatic wait_st(input logic [4:0] st, input int n_exp);
        int n;
        n = 0;
        do
        begin
            @(negedge sys_clk);
            n++;
        end
        while (radio_state_number !== st && n < 30000);
        chk({27'h0, radio_state_number}, {27'h0, st});
        if (n_exp > 0)
            chk(n, n_exp);
    endtask

    task automatic report_and_stop();
        if (err_total == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // hang guard, well beyond the longest expected run
    initial
    begin
        #(60000 * 50);
        err_total++;
        report_and_stop();
    end

    // main sequence
    initial
    begin
        sys_clk = 0; nrst = 0; wr = 0; rd = 0; addr = 0; wdata = 0;
        pkt_rx_done = 0; pkt_tx_done = 0; tx_underflow = 0; sync_found = 0;
        pq_reached = 0; cs_valid = 0; carrier = 0; rssi_below = 0; rx_busy = 0;
        err_total = 0; n_compared = 0;
        repeat (8) @(posedge sys_clk);
        nrst <= 1'b1;
        rd_chk(`RCSM_OFF_STATE, 32'h01);
        rd_chk(`RCSM_OFF_CFG1, 32'h30);
        rd_chk(`RCSM_OFF_CFG0, 32'h0);
        rd_chk(8'h20, 32'h0);                                // unmapped reads zero
        strobe(`RCSM_CMD_RX);
        wait_st(`RCSM_ST_RX, 1955);
        chk(rx_on, 1'b1);
        chk(rssi_valid, 1'b0);
        // busy channel: transmit request refused, receive kept
        strobe(`RCSM_CMD_TX);
        repeat (20) @(negedge sys_clk);
        chk(radio_state_number, `RCSM_ST_RX);
        @(posedge sys_clk) rssi_below <= 1'b1;
        strobe(`RCSM_CMD_TX);
        wait_st(`RCSM_ST_TX, 784);
        chk(tx_on, 1'b1);
        @(posedge sys_clk) pkt_tx_done <= 1'b1;
        @(posedge sys_clk) pkt_tx_done <= 1'b0;
        wait_st(`RCSM_ST_IDLE, 0);
        // manual calibration
        strobe(`RCSM_CMD_CAL);
        @(negedge sys_clk);
        chk(synth_cal, 1'b1);
        wait_st(`RCSM_ST_IDLE, T_SHORT + 1);
        // calibrate on leaving idle, after-receive goes to synth ready
        wr_reg(`RCSM_OFF_CFG0, 32'h1);
        wr_reg(`RCSM_OFF_CFG1, 32'h34);
        strobe(`RCSM_CMD_TX);
        wait_st(`RCSM_ST_TX, T_SHORT + 2);
        strobe(`RCSM_CMD_RX);
        wait_st(`RCSM_ST_RX, 782 + QSYM + 2);
        @(posedge sys_clk) pkt_rx_done <= 1'b1;
        @(posedge sys_clk) pkt_rx_done <= 1'b0;
        wait_st(`RCSM_ST_SYNTH_READY_TX_STATE, 0);
        strobe(`RCSM_CMD_IDLE);
        wait_st(`RCSM_ST_IDLE, 1);
        strobe(`RCSM_CMD_RX);
        wait_st(`RCSM_ST_RX, T_SHORT + 2);
        strobe(`RCSM_CMD_IDLE);
        wait_st(`RCSM_ST_IDLE, 1);
        // termination timer: one unit, preamble quality keeps receive
        wr_reg(`RCSM_OFF_CFG0, 32'h0);
        wr_reg(`RCSM_OFF_RXTIME, 32'h1);
        wr_reg(`RCSM_OFF_CFG2, 32'h1);
        @(posedge sys_clk) pq_reached <= 1'b1;
        strobe(`RCSM_CMD_RX);
        wait_st(`RCSM_ST_RX, 1955);
        repeat (300) @(negedge sys_clk);
        chk(radio_state_number, `RCSM_ST_RX);
        chk(rssi_valid, 1'b1);
        // stay in receive after a packet: rssi stale again
        wr_reg(`RCSM_OFF_CFG1, 32'h3C);
        @(posedge sys_clk) pkt_rx_done <= 1'b1;
        @(posedge sys_clk) pkt_rx_done <= 1'b0;
        @(negedge sys_clk);
        chk(rssi_valid, 1'b0);
        chk(radio_state_number, `RCSM_ST_RX);
        strobe(`RCSM_CMD_IDLE);
        wr_reg(`RCSM_OFF_CFG2, 32'h0);
        strobe(`RCSM_CMD_RX);
        wait_st(`RCSM_ST_RX, 1955);
        wait_st(`RCSM_ST_IDLE, 67);
        // carrier sense termination on the first valid sample
        wr_reg(`RCSM_OFF_CFG2, 32'h2);
        @(posedge sys_clk) cs_valid <= 1'b1;
        strobe(`RCSM_CMD_RX);
        wait_st(`RCSM_ST_RX, 1955);
        wait_st(`RCSM_ST_IDLE, 4);
        // transmit underflow is an internal event back to idle, calibrating
        wr_reg(`RCSM_OFF_CFG0, 32'h2);
        strobe(`RCSM_CMD_TX);
        wait_st(`RCSM_ST_TX, 1956);
        @(posedge sys_clk) tx_underflow <= 1'b1;
        @(posedge sys_clk) tx_underflow <= 1'b0;
        wait_st(`RCSM_ST_IDLE, T_SHORT + QSYM + 2);
        report_and_stop();
    end
endmodule // testbench

bind rcsm_ctrl rcsm_ctrl_monitor rcsm_ctrl_monitor_i (
    .sys_clk(sys_clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .pkt_rx_done(pkt_rx_done), .pkt_tx_done(pkt_tx_done),
    .tx_underflow(tx_underflow), .sync_found(sync_found), .pq_reached(pq_reached),
    .cs_valid(cs_valid), .carrier(carrier), .rssi_below(rssi_below), .rx_busy(rx_busy),
    .radio_state_number(radio_state_number), .synth_cal(synth_cal), .rx_on(rx_on),
    .tx_on(tx_on), .rssi_valid(rssi_valid));
`default_nettype wire
